// *** rtl/pctb_timer.sv ***
/*
  8-bit up counter with preload, pulse width capture and a tone
  divider driving a complementary pair on port a bits 0 and 1.
  assumes one 10 MHz clock, a synchronous active-low reset and a
  register master that never waits; the timer pin is asynchronous.
*/
// The implementer's own choices: the strobed register port and the address map.
// Function
// - capture clock: system clock or quarter, prescaled
// - enable arms counter; waits for active edge
// - edge low: falling starts, rising stops
// - edge high: rising starts, falling stops
// - capture end clears enable; else software only
// - residual kept; ignore pin until re-enabled
// - react to pin transitions only, not levels
// - overflow: interrupt, reload preload, keep counting
// - overflow sets request flag; enable gates interrupt
// - powered down: overflow wakes regardless of enable
// - request flag set blocks overflow wake-up
// - counter read or preload write inhibits clock
// - pin edges seen at next timer tick; event mode counts an edge as soon as it is detected
// - each overflow toggles tone outputs
// - second tone output inverts the first
// - tone field selects single or pair output
// - port a bit0 zero forces tones low
// - port a bit1 data never affects tones
// - tone drives output pins only; inputs stay inputs
// - mode codes: none, event, timer, capture
// - prescale divides by 1 to 128
// - enable zero stops, one allows counting
`timescale 1ns/10ps
`include "pctb_regs.svh"

module pctb_timer
  import pctb_pkg::*;
(
  input  wire logic       clk,        // 10 MHz system clock
  input  wire logic       rst_n,      // synchronous reset, active low
  input  wire logic [2:0] addr,       // register address
  input  wire logic [7:0] wdata,      // write data
  input  wire logic       wr,         // write strobe
  input  wire logic       rd,         // read strobe
  output logic      [7:0] rdata,      // read data, cycle after rd
  input  wire logic       timer_pin,  // asynchronous timer input pin
  input  wire logic [1:0] pa_in,      // port a bits 1..0 pin levels
  output logic      [1:0] pa_out,     // port a bits 1..0 drive value
  output logic      [1:0] pa_oe,      // port a bits 1..0 output enables
  output logic            timer_irq,  // timer interrupt, level
  output logic            wake        // wake-up request, level
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] preload;
  logic [7:0] count;
  logic       int_en;
  logic       int_req;
  logic [1:0] tone_sel;
  logic       clk_sel;
  logic       pdown;
  logic [1:0] pa_dir;
  logic [1:0] pa_data;
  logic       tone;
  logic [6:0] psc;
  logic [1:0] sysdiv;
  logic       sync1;
  logic       sync2;
  logic       pin_q;
  logic       edge_pend;
  logic       pend_level;
  pctb_cap_e  cap;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        wr_ctrl  = wr && (addr == `PCTB_OFF_CTRL);
  wire        wr_cnt   = wr && (addr == `PCTB_OFF_COUNT);
  wire        wr_intc  = wr && (addr == `PCTB_OFF_INTC);
  wire        wr_sys   = wr && (addr == `PCTB_OFF_SYSC0);
  wire        wr_dir   = wr && (addr == `PCTB_OFF_PADIR);
  wire        wr_dat   = wr && (addr == `PCTB_OFF_PADATA);
  wire        rd_cnt   = rd && (addr == `PCTB_OFF_COUNT);

  wire        cnt_en   = ctrl[`PCTB_EN_BIT];
  wire        edge_hi  = ctrl[`PCTB_EDGE_BIT];
  wire [2:0]  psc_sel  = ctrl[`PCTB_PSC_HI:`PCTB_PSC_LO];
  pctb_mode_e mode;
  assign mode = pctb_mode_e'(ctrl[`PCTB_MODE_HI:`PCTB_MODE_LO]);

  // ----------------------------------------------------------------
  // timer clock: system clock or quarter, then prescaler
  // ----------------------------------------------------------------
  wire        base_tick = clk_sel ? (sysdiv == `PCTB_SYSDIV) : 1'b1;
  wire [7:0]  psc_ext   = {psc, 1'b1};
  // power of two division: tick when low psc_sel bits of counter all set
  wire [7:0]  psc_mask  = 8'((9'h001 << psc_sel) - 9'h001);
  wire        psc_tick  = base_tick && ((psc_ext[7:1] & psc_mask[6:0]) == psc_mask[6:0]);
  // host access steals the tick; a count may be lost
  wire        inhibit   = rd_cnt || wr_cnt;
  wire        tick      = psc_tick && !inhibit;

  // ----------------------------------------------------------------
  // pin synchroniser and edge detection
  // ----------------------------------------------------------------
  wire        rise      = sync2 && !pin_q;
  wire        fall      = !sync2 && pin_q;
  wire        start_ev  = edge_hi ? rise : fall;
  wire        stop_ev   = edge_hi ? fall : rise;
  wire        is_cap    = (mode == PCTB_MODE_CAPTURE);
  wire        is_evt    = (mode == PCTB_MODE_EVENT);
  wire        is_tmr    = (mode == PCTB_MODE_TIMER);
  wire        evt_edge  = edge_hi ? fall : rise;

  // edges held until the next timer tick, then acted on
  wire        seen_start = edge_pend && pend_level;
  wire        seen_stop  = edge_pend && !pend_level;

  wire        run      = is_tmr ? (cnt_en && tick)
                       : is_evt ? (cnt_en && evt_edge)
                       : is_cap ? (cap == PCTB_CAP_RUN && tick && !seen_stop)
                       : 1'b0;
  wire        ovf      = run && (count == 8'hff);
  wire        cap_end  = is_cap && cap == PCTB_CAP_RUN && tick && seen_stop;

  logic [7:0] next_count;
  always_comb
  begin
    next_count = count;
    if (wr_cnt)
      next_count = count;
    else if (ovf)
      next_count = preload;
    else if (run)
      next_count = count + 8'h01;
  end

  // ----------------------------------------------------------------
  // tone outputs
  // ----------------------------------------------------------------
  wire        tone_on  = tone_sel[`PCTB_TONE_HI];
  wire        pair_on  = tone_on && tone_sel[`PCTB_TONE_LO];
  // pa_data[1] deliberately unused for the tone path
  wire        bz       = pa_data[0] ? tone : 1'b0;
  wire        bz_n     = pa_data[0] ? !tone : 1'b0;

  assign pa_oe[0]  = !pa_dir[0];
  assign pa_oe[1]  = !pa_dir[1];
  assign pa_out[0] = tone_on ? bz : pa_data[0];
  assign pa_out[1] = pair_on ? bz_n : pa_data[1];

  assign timer_irq = int_req && int_en;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    case (addr)
      `PCTB_OFF_CTRL:   rd_mux = ctrl & `PCTB_CTRL_MASK;
      `PCTB_OFF_COUNT:  rd_mux = count;
      `PCTB_OFF_INTC:   rd_mux = {6'h00, int_req, int_en};
      `PCTB_OFF_SYSC0:  rd_mux = {4'h0, pdown, clk_sel, tone_sel};
      `PCTB_OFF_PADIR:  rd_mux = {6'h00, pa_dir};
      `PCTB_OFF_PADATA: rd_mux = {6'h00, pa_in};
      `PCTB_OFF_STATUS: rd_mux = {5'h00, sync2, cap};
      default:          rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // capture sequencing and enable bit
  // ----------------------------------------------------------------
  logic [7:0] next_ctrl;
  pctb_cap_e  next_cap;
  always_comb
  begin
    next_ctrl = ctrl;
    next_cap  = cap;
    if (!is_cap || !cnt_en)
      next_cap = PCTB_CAP_IDLE;
    else if (cap == PCTB_CAP_IDLE)
      next_cap = PCTB_CAP_ARMED;
    else if (cap == PCTB_CAP_ARMED && tick && seen_start)
      next_cap = PCTB_CAP_RUN;
    if (cap_end)
    begin
      next_ctrl[`PCTB_EN_BIT] = 1'b0;
      next_cap = PCTB_CAP_IDLE;
    end
    if (wr_ctrl)
    begin
      next_ctrl = wdata & `PCTB_CTRL_MASK;
      // a write that re-arms restarts the one-shot
      if (cap_end && !wdata[`PCTB_EN_BIT])
        next_ctrl[`PCTB_EN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    sync1 <= timer_pin;
    sync2 <= sync1;
    pin_q <= sync2;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      edge_pend  <= 1'b0;
      pend_level <= 1'b0;
    end
    else if (cap == PCTB_CAP_ARMED && start_ev)
    begin
      edge_pend  <= 1'b1;
      pend_level <= 1'b1;
    end
    else if (cap == PCTB_CAP_RUN && stop_ev)
    begin
      edge_pend  <= 1'b1;
      pend_level <= 1'b0;
    end
    else if (tick || cap == PCTB_CAP_IDLE)
      edge_pend  <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl   <= `PCTB_CTRL_RST;
      cap    <= PCTB_CAP_IDLE;
      count  <= 8'h00;
      preload <= 8'h00;
      psc    <= 7'h00;
      sysdiv <= 2'h0;
      tone   <= 1'b0;
    end
    else
    begin
      ctrl   <= next_ctrl;
      cap    <= next_cap;
      count  <= next_count;
      sysdiv <= sysdiv + 2'h1;
      if (base_tick)
        psc <= psc + 7'h01;
      if (wr_cnt)
        preload <= wdata;
      if (ovf)
        tone <= !tone;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      int_en   <= 1'b0;
      int_req  <= 1'b0;
      tone_sel <= 2'h0;
      clk_sel  <= 1'b0;
      pdown    <= 1'b0;
      pa_dir   <= 2'h3;
      pa_data  <= 2'h0;
      wake     <= 1'b0;
      rdata    <= 8'h00;
    end
    else
    begin
      rdata <= rd ? rd_mux : 8'h00;
      if (wr_intc)
      begin
        int_en  <= wdata[`PCTB_INT_EN_BIT];
        int_req <= wdata[`PCTB_INT_REQ_BIT] || ovf;
      end
      else if (ovf)
        int_req <= 1'b1;
      if (wr_sys)
      begin
        tone_sel <= wdata[`PCTB_TONE_HI:`PCTB_TONE_LO];
        clk_sel  <= wdata[`PCTB_CLKSEL_BIT];
        pdown    <= wdata[`PCTB_PDOWN_BIT];
      end
      if (wr_dir)
        pa_dir  <= wdata[1:0];
      if (wr_dat)
        pa_data <= wdata[1:0];
      // flag already set before sleep masks the wake
      if (!pdown)
        wake <= 1'b0;
      else if (ovf && !int_req)
        wake <= 1'b1;
    end
  end

endmodule // pctb_timer

// *** rtl/pctb_regs.svh ***
/*
  register offsets, field positions, reset values and timing for the
  pulse capture timer with tone output.
  assumes inclusion by bare name from the package and the design.
*/
`ifndef PCTB_REGS_SVH
`define PCTB_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCTB_ADDR_W        3
`define PCTB_OFF_CTRL      3'h0
`define PCTB_OFF_COUNT     3'h1
`define PCTB_OFF_INTC      3'h2
`define PCTB_OFF_SYSC0     3'h3
`define PCTB_OFF_PADIR     3'h4
`define PCTB_OFF_PADATA    3'h5
`define PCTB_OFF_STATUS    3'h6

// ----------------------------------------------------------------
// timer control fields
// ----------------------------------------------------------------
`define PCTB_MODE_HI       7
`define PCTB_MODE_LO       6
`define PCTB_EN_BIT        4
`define PCTB_EDGE_BIT      3
`define PCTB_PSC_HI        2
`define PCTB_PSC_LO        0
`define PCTB_CTRL_RST      8'h08
`define PCTB_CTRL_MASK     8'hdf

// ----------------------------------------------------------------
// interrupt control, system control 0, status, port fields
// ----------------------------------------------------------------
`define PCTB_INT_EN_BIT    0
`define PCTB_INT_REQ_BIT   1
`define PCTB_TONE_HI       1
`define PCTB_TONE_LO       0
`define PCTB_CLKSEL_BIT    2
`define PCTB_PDOWN_BIT     3
`define PCTB_TIN_BIT       2
`define PCTB_PADIR_RST     8'hff
`define PCTB_SYSDIV        2'h3

`endif

// *** rtl/pctb_pkg.sv ***
/*
  types shared by the pulse capture timer design.
  assumes the register header sits beside it.
*/
package pctb_pkg;
  `include "pctb_regs.svh"

  typedef enum logic [1:0] {
    PCTB_MODE_NONE,
    PCTB_MODE_EVENT,
    PCTB_MODE_TIMER,
    PCTB_MODE_CAPTURE
  } pctb_mode_e;

  typedef enum logic [1:0] {
    PCTB_CAP_IDLE,
    PCTB_CAP_ARMED,
    PCTB_CAP_RUN
  } pctb_cap_e;
endpackage

// *** bench/pctb_timer_sva.sv ***
/*
  port-level checker for the pulse capture timer.
  assumes the register offsets of the shared header; shadows the
  port, tone and interrupt enable registers from bus writes.
*/
`timescale 1ns/10ps
`include "pctb_regs.svh"
module pctb_timer_sva
  import pctb_pkg::*;
(
  input wire logic       clk,        // system clock
  input wire logic       rst_n,      // synchronous reset, active low
  input wire logic [2:0] addr,       // register address
  input wire logic [7:0] wdata,      // write data
  input wire logic       wr,         // write strobe
  input wire logic       rd,         // read strobe
  input wire logic [7:0] rdata,      // read data
  input wire logic [1:0] pa_out,     // port drive value
  input wire logic [1:0] pa_oe,      // port output enables
  input wire logic       timer_irq,  // timer interrupt
  input wire logic       wake        // wake-up request
);
  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  logic [3:0] sysc, next_sysc;
  logic [1:0] dir, next_dir, dat, next_dat;
  logic       ien, next_ien;
  assign next_sysc = (wr && addr == `PCTB_OFF_SYSC0) ? wdata[3:0] : sysc;
  assign next_dir  = (wr && addr == `PCTB_OFF_PADIR) ? wdata[1:0] : dir;
  assign next_dat  = (wr && addr == `PCTB_OFF_PADATA) ? wdata[1:0] : dat;
  assign next_ien  = (wr && addr == `PCTB_OFF_INTC) ? wdata[0] : ien;
  always_ff @(posedge clk)
  begin
    sysc <= rst_n ? next_sysc : 4'h0;
    dir  <= rst_n ? next_dir : 2'h3;
    dat  <= rst_n ? next_dat : 2'h0;
    ien  <= rst_n ? next_ien : 1'b0;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_unmapped_a: assert property (rd && addr == 3'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_quiet_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");
  oe_follow_a: assert property (pa_oe == ~dir)
    else $error("output enable not inverse of direction");
  data_plain_a: assert property (!sysc[1] |-> pa_out == dat)
    else $error("plain port data altered");
  single_tone_a: assert property (sysc[1:0] == 2'b10 |-> pa_out[1] == dat[1])
    else $error("single tone touched bit 1");
  pair_inv_a: assert property (sysc[1:0] == 2'b11 && dat[0] |-> pa_out[1] == ~pa_out[0])
    else $error("tone pair not complementary");
  tone_off_a: assert property (sysc[1] && !dat[0] |-> pa_out[0] == 1'b0
    && pa_out[1] == (sysc[0] ? 1'b0 : dat[1]))
    else $error("tone not low with data bit 0 clear");
  irq_gate_a: assert property (!ien |-> !timer_irq)
    else $error("interrupt while disabled");
  wake_src_a: assert property ($rose(wake) |-> $past(sysc[3]))
    else $error("wake without power-down");
  wake_clear_a: assert property (!sysc[3] && !$past(sysc[3]) |-> !wake)
    else $error("wake held after power-down left");
  tone_ovf_a: assert property ($changed(pa_out[0]) && $stable(sysc) && $stable(dat)
    && sysc[1] && dat[0] && ien |-> timer_irq)
    else $error("tone toggled without overflow");
endmodule // pctb_timer_sva

bind pctb_timer pctb_timer_sva pctb_timer_sva_i (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_out(pa_out), .pa_oe(pa_oe),
  .timer_irq(timer_irq), .wake(wake));

// *** bench/pctb_pulse_src.sv ***
/*
  external pulse source on the timer pin.
  assumes the bench sets the idle level before arming a capture.
*/
`timescale 1ns/10ps
module pctb_pulse_src (
  input wire logic clk,       // system clock, for pulse timing only
  input wire logic idle_lvl,  // level the released line rests at
  output logic     pin        // timer pin
);
  logic active = 1'b0;
  // released line rests at the pulled level
  assign pin = active ? ~idle_lvl : idle_lvl;
  // edges land off the clock on purpose: the pin is asynchronous
  task automatic pulse(input int cycles);
    @(posedge clk);
    #37 active = 1'b1;
    repeat (cycles) @(posedge clk);
    #37 active = 1'b0;
  endtask
endmodule // pctb_pulse_src

// *** bench/testbench.sv ***
/*
  self-checking bench for the pulse capture timer.
  assumes a 10 MHz clock and the register map of the shared header.
*/
`timescale 1ns/10ps
`include "pctb_regs.svh"
module testbench;
  import pctb_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, idle_lvl = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, v, c0, t;
  logic [1:0] pa_in = 2'h0, pa_out, pa_oe;
  logic       timer_pin, timer_irq, wake, t0;
  logic [2:0] ra[4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  logic [7:0] rm[4] = '{8'h1f, 8'h03, 8'h0f, 8'h03};
  int         failures = 0, comparisons = 0, cycles = 0, w, n;

  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000) finish_test(1'b1);
  end

  pctb_timer pctb_timer_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_pin(timer_pin), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .timer_irq(timer_irq), .wake(wake));
  pctb_pulse_src pctb_pulse_src_i (.clk(clk), .idle_lvl(idle_lvl), .pin(timer_pin));

  // ----------------------------------------------------------------
  // bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand only until the next edge: take them 1 ns after this one
    #1 d = rdata;
  endtask
  task automatic wait_hi(input bit sel, input int bound);
    n = 0;
    while (((sel ? wake : timer_irq) !== 1'b1) && n < bound)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // one tick of slack: the pin edge lands anywhere within a tick
  function automatic bit near(input logic [7:0] got, input int e);
    return int'(got) >= e - 1 && int'(got) <= e + 1;
  endfunction
  task automatic finish_test(input bit hang);
    if (hang) failures++;
    $display("counts: comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(85751));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`PCTB_OFF_CTRL, t); `CHK(t, `PCTB_CTRL_RST)
    rd_reg(`PCTB_OFF_PADIR, t); `CHK(t[1:0], 2'h3)
    `CHK(pa_oe, 2'h0)
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      pa_in <= 2'($urandom);
      w = $urandom_range(0, 3);
      v = 8'($urandom) & rm[w];
      wr_reg(ra[w], v);
      rd_reg(ra[w], t); `CHK(t, v)
      rd_reg(`PCTB_OFF_PADATA, t); `CHK(t[1:0], pa_in)
    end
    wr_reg(3'h7, 8'hff);
    rd_reg(3'h7, t); `CHK(t, 8'h00)
    wr_reg(`PCTB_OFF_INTC, 8'h00);
    wr_reg(`PCTB_OFF_COUNT, 8'h00);
    $display("test registers done");
    // p = 8 runs undivided from the quarter clock
    for (int p = 0; p < 9; p++)
    begin
      idle_lvl <= ~p[0];
      wr_reg(`PCTB_OFF_SYSC0, (p == 8) ? 8'h04 : 8'h00);
      repeat (6) @(posedge clk);
      rd_reg(`PCTB_OFF_COUNT, c0);
      v = {2'b11, 1'b0, 1'b1, p[0], 3'(p % 8)};
      wr_reg(`PCTB_OFF_CTRL, v);
      repeat (10) @(posedge clk);
      rd_reg(`PCTB_OFF_COUNT, t); `CHK(t, c0)
      w = $urandom_range(6, 9);
      for (int k = 0; k < 2; k++)
      begin
        pctb_pulse_src_i.pulse(w * ((p == 8) ? 4 : (1 << p)));
        repeat ((2 << (p % 8)) + 12) @(posedge clk);
        rd_reg(`PCTB_OFF_COUNT, t);
        `CHK(near(t - c0, w), 1'b1)
      end
      rd_reg(`PCTB_OFF_CTRL, t); `CHK(t, v & 8'hef)
      rd_reg(`PCTB_OFF_STATUS, t); `CHK(t[2:0], {~p[0], 2'b00})
    end
    rd_reg(`PCTB_OFF_COUNT, c0);
    wr_reg(`PCTB_OFF_CTRL, 8'h50);
    repeat (3) pctb_pulse_src_i.pulse(5);
    repeat (8) @(posedge clk);
    rd_reg(`PCTB_OFF_COUNT, t); `CHK(t, c0 + 8'h03)
    $display("test capture done");
    wr_reg(`PCTB_OFF_SYSC0, 8'h03);
    wr_reg(`PCTB_OFF_PADIR, 8'h00);
    wr_reg(`PCTB_OFF_PADATA, 8'h01);
    wr_reg(`PCTB_OFF_COUNT, 8'hf0);
    wr_reg(`PCTB_OFF_INTC, 8'h01);
    wr_reg(`PCTB_OFF_CTRL, 8'h90);
    wait_hi(1'b0, 600);
    t0 = pa_out[0];
    `CHK(pa_out[1], ~t0)
    rd_reg(`PCTB_OFF_INTC, t); `CHK(t, 8'h03)
    rd_reg(`PCTB_OFF_COUNT, t); `CHK(t >= 8'hf0, 1'b1)
    wr_reg(`PCTB_OFF_INTC, 8'h01);
    repeat (2) @(posedge clk);
    wait_hi(1'b0, 40);
    `CHK(timer_irq, 1'b1)
    `CHK(pa_out[0], ~t0)
    wr_reg(`PCTB_OFF_INTC, 8'h00);
    repeat (40) @(posedge clk);
    `CHK(timer_irq, 1'b0)
    rd_reg(`PCTB_OFF_INTC, t); `CHK(t, 8'h02)
    wr_reg(`PCTB_OFF_PADATA, 8'h02);
    wr_reg(`PCTB_OFF_PADIR, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(pa_out, 2'h0)
    `CHK(pa_oe, 2'h2)
    $display("test overflow done");
    wr_reg(`PCTB_OFF_SYSC0, 8'h0b);
    repeat (40) @(posedge clk);
    `CHK(wake, 1'b0)
    wr_reg(`PCTB_OFF_INTC, 8'h00);
    wait_hi(1'b1, 40);
    `CHK(wake, 1'b1)
    wr_reg(`PCTB_OFF_SYSC0, 8'h03);
    repeat (3) @(posedge clk);
    `CHK(wake, 1'b0)
    $display("test wake done");
    finish_test(1'b0);
  end
endmodule // testbench
